// [hdl/stm_self_test.sv]
// The Wishbone interface to the registers and the address map were left to the implementer.
`default_nettype none

// Shift FIFO: head always in slot 0 so the read side comes straight from flops
module stm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   typedef struct packed {
      logic [DEPTH-1:0] vld;
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } stm_fifo_st_t;
   stm_fifo_st_t st_q, st_d;
   logic pop;
   logic push;

   // Pop shifts toward the head, push lands in the first free slot after it
   always_comb begin
      st_d = st_q;
      pop = st_q.vld[0] && out_ready_i;
      push = in_valid_i && !st_q.vld[DEPTH-1];
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            st_d.vld[i] = st_q.vld[i+1];
            st_d.mem[i] = st_q.mem[i+1];
         end
         st_d.vld[DEPTH-1] = 1'b0;
      end
      if (push) begin
         for (int i = DEPTH - 1; i >= 0; i--) begin
            if (!st_d.vld[i]) begin
               st_d.mem[i] = in_data_i;
            end
         end
         // The head is always valid after a push; above it, the first free slot is marked
         for (int i = DEPTH - 1; i > 0; i--) begin
            if (!st_d.vld[i] && st_d.vld[i-1]) begin
               st_d.vld[i] = 1'b1;
            end
         end
         st_d.vld[0] = 1'b1;
      end
   end

   // Full is judged before a pop, trading one cycle of throughput for a ready path straight from a flop
   assign in_ready_o = !st_q.vld[DEPTH-1];
   assign out_valid_o = st_q.vld[0];
   assign out_data_o = st_q.mem[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // stm_fifo

module stm_self_test #(
   parameter int unsigned TIMEOUT_CYC = stm_pkg::STM_TEST_MAX_CYC,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic [1:0] ant_sense_i,
   output logic test_start_o,
   input wire logic test_done_i,
   input wire logic [7:0] test_misc_fail_i,
   input wire logic [11:0] test_chan_fail_i,
   output logic store_protect_o,
   output logic acq_restart_o
);
   stm_pkg::stm_state_t st_q, st_d;
   stm_pkg::stm_wb_req_t wb;
   stm_pkg::stm_chk_t chk;
   logic req_hit;
   logic go;
   logic fin;
   logic wb_take;
   logic push;
   logic fifo_rdy;
   logic [7:0] push_byte;

   // Expected request byte at a parser position
   function automatic logic [7:0] req_byte(input logic [2:0] idx);
      case (idx)
         3'h0, 3'h1: req_byte = stm_pkg::STM_SYNC_BYTE;
         3'h2: req_byte = stm_pkg::STM_ID_HI;
         3'h3: req_byte = stm_pkg::STM_ID_LO;
         3'h4: req_byte = stm_pkg::STM_REQ_CSUM;
         3'h5: req_byte = stm_pkg::STM_CR;
         default: req_byte = stm_pkg::STM_LF;
      endcase
   endfunction

   // Place every check in its fixed slot; spares are forced to pass
   function automatic logic [23:0] pack_result(input logic [1:0] ant, input stm_pkg::stm_chk_t c);
      pack_result = {ant, c.misc[7:6], 1'b0, c.misc[5:3], 1'b0, c.misc[2:0], c.chan};
   endfunction

   // Checksum is the XOR of id and payload bytes
   function automatic logic [7:0] rsp_csum(input logic [23:0] r);
      rsp_csum = stm_pkg::STM_ID_HI ^ stm_pkg::STM_ID_LO ^ r[23:16] ^ r[15:8] ^ r[7:0];
   endfunction

   assign wb = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
   assign chk = '{misc: test_misc_fail_i, chan: test_chan_fail_i};

   // Response bytes in wire order, result most significant first
   always_comb begin
      case (st_q.tx_idx)
         4'h0, 4'h1: push_byte = stm_pkg::STM_SYNC_BYTE;
         4'h2: push_byte = stm_pkg::STM_ID_HI;
         4'h3: push_byte = stm_pkg::STM_ID_LO;
         4'h4: push_byte = st_q.result[23:16];
         4'h5: push_byte = st_q.result[15:8];
         4'h6: push_byte = st_q.result[7:0];
         4'h7: push_byte = st_q.csum;
         4'h8: push_byte = stm_pkg::STM_CR;
         default: push_byte = stm_pkg::STM_LF;
      endcase
   end

   stm_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_data_i(push_byte),
      .in_ready_o(fifo_rdy),
      .out_valid_o(tx_valid_o),
      .out_data_o(tx_data_o),
      .out_ready_i(tx_ready_i)
   );

   // Next-state logic for parser, sequencer and register file
   always_comb begin
      st_d = st_q;
      st_d.ant_s1 = ant_sense_i;
      st_d.ant_s2 = st_q.ant_s1;
      st_d.test_start = 1'b0;
      st_d.acq_restart = 1'b0;
      wb_take = wb.cyc && wb.stb && !st_q.wb_ack;
      go = 1'b0;
      fin = 1'b0;
      push = 1'b0;
      req_hit = 1'b0;

      // Request parser; a stray sync byte restarts the match at position one
      if (rx_valid_i) begin
         if (rx_data_i == req_byte(st_q.rx_idx)) begin
            if (st_q.rx_idx == stm_pkg::STM_REQ_LEN - 3'h1) begin
               st_d.rx_idx = 3'h0;
               req_hit = 1'b1;
            end else begin
               st_d.rx_idx = st_q.rx_idx + 3'h1;
            end
         end else if (rx_data_i == stm_pkg::STM_SYNC_BYTE) begin
            st_d.rx_idx = 3'h1;
         end else begin
            st_d.rx_idx = 3'h0;
         end
      end

      // Register bus: one wait state, unmapped reads return zero
      st_d.wb_ack = wb_take;
      st_d.wb_dat = '0;
      if (wb_take && wb.we && wb.sel[0]) begin
         if (wb.adr == stm_pkg::STM_ADR_CTRL) begin
            st_d.ctrl_en = wb.dat[stm_pkg::STM_CTRL_EN_BIT];
            go = wb.dat[stm_pkg::STM_CTRL_GO_BIT];
         end else if (wb.adr == stm_pkg::STM_ADR_STATUS) begin
            if (wb.dat[stm_pkg::STM_STAT_DONE_BIT]) begin
               st_d.done_flag = 1'b0;
            end
            if (wb.dat[stm_pkg::STM_STAT_TMO_BIT]) begin
               st_d.tmo_flag = 1'b0;
            end
         end
      end
      if (wb_take && !wb.we) begin
         case (wb.adr)
            stm_pkg::STM_ADR_CTRL: st_d.wb_dat[stm_pkg::STM_CTRL_EN_BIT] = st_q.ctrl_en;
            stm_pkg::STM_ADR_STATUS: begin
               st_d.wb_dat[stm_pkg::STM_STAT_BUSY_BIT] = (st_q.fsm != stm_pkg::ST_IDLE);
               st_d.wb_dat[stm_pkg::STM_STAT_DONE_BIT] = st_q.done_flag;
               st_d.wb_dat[stm_pkg::STM_STAT_TMO_BIT] = st_q.tmo_flag;
            end
            stm_pkg::STM_ADR_RESULT: st_d.wb_dat[23:0] = st_q.result;
            default: st_d.wb_dat = '0;
         endcase
      end

      // Sequencer; requests while a test is under way are dropped
      case (st_q.fsm)
         stm_pkg::ST_IDLE: begin
            if ((req_hit && st_q.ctrl_en) || go) begin
               st_d.fsm = stm_pkg::ST_RUN;
               st_d.test_start = 1'b1;
               st_d.protect = 1'b1;
               st_d.tmo_cnt = '0;
            end
         end
         stm_pkg::ST_RUN: begin
            st_d.tmo_cnt = st_q.tmo_cnt + 32'h1;
            if (test_done_i) begin
               st_d.result = pack_result(st_q.ant_s2, chk);
               st_d.csum = rsp_csum(pack_result(st_q.ant_s2, chk));
               fin = 1'b1;
            end else if (st_q.tmo_cnt >= TIMEOUT_CYC - 32'h1) begin
               // Unfinished checks count as failed; the antenna pins are still valid
               st_d.result = pack_result(st_q.ant_s2, '1);
               st_d.csum = rsp_csum(pack_result(st_q.ant_s2, '1));
               st_d.tmo_flag = 1'b1;
               fin = 1'b1;
            end
            if (fin) begin
               st_d.fsm = stm_pkg::ST_SEND;
               st_d.tx_idx = 4'h0;
               st_d.protect = 1'b0;
            end
         end
         stm_pkg::ST_SEND: begin
            push = fifo_rdy; // FIFO back-pressure stalls the frame
            if (fifo_rdy) begin
               if (st_q.tx_idx == stm_pkg::STM_RSP_LEN - 4'h1) begin
                  st_d.fsm = stm_pkg::ST_RESTART;
               end else begin
                  st_d.tx_idx = st_q.tx_idx + 4'h1;
               end
            end
         end
         stm_pkg::ST_RESTART: begin
            st_d.acq_restart = 1'b1;
            st_d.fsm = stm_pkg::ST_IDLE;
         end
         default: st_d.fsm = stm_pkg::ST_IDLE;
      endcase
      // Set beats a same-cycle software clear
      if (st_q.fsm == stm_pkg::ST_RESTART) begin
         st_d.done_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.fsm <= stm_pkg::ST_IDLE;
         st_q.ctrl_en <= stm_pkg::STM_CTRL_EN_RST;
         st_q.result <= stm_pkg::STM_RESULT_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack_o = st_q.wb_ack;
   assign wb_dat_o = st_q.wb_dat;
   assign test_start_o = st_q.test_start;
   assign store_protect_o = st_q.protect;
   assign acq_restart_o = st_q.acq_restart;

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_START_ON_REQ: assert property ((st_q.fsm == stm_pkg::ST_IDLE && req_hit && st_q.ctrl_en)
      |=> test_start_o && st_q.fsm == stm_pkg::ST_RUN) else $error("request not started");
   AST_START_PROTECT: assert property (test_start_o |-> store_protect_o)
      else $error("store protect missing during test");
   AST_CHECKS_RUN: assert property ($rose(test_start_o) |-> st_q.fsm == stm_pkg::ST_RUN)
      else $error("start without run");
   AST_TIMEOUT: assert property (st_q.fsm == stm_pkg::ST_RUN |-> st_q.tmo_cnt < TIMEOUT_CYC)
      else $error("self-test exceeded time budget");
   AST_PASS_ZERO: assert property ((st_q.fsm == stm_pkg::ST_RUN && test_done_i && chk == '0
      && st_q.ant_s2 == 2'h0) |=> st_q.result == 24'h000000) else $error("pass not zero");
   AST_FAIL_ONE: assert property ((st_q.fsm == stm_pkg::ST_RUN && test_done_i)
      |=> st_q.result[21] == $past(test_misc_fail_i[7])) else $error("clock bit wrong");
   AST_ANT: assert property ((st_q.fsm == stm_pkg::ST_RUN && test_done_i)
      |=> st_q.result[23:22] == $past(st_q.ant_s2)) else $error("antenna field wrong");
   AST_CHAN: assert property ((st_q.fsm == stm_pkg::ST_RUN && test_done_i)
      |=> st_q.result[11:0] == $past(test_chan_fail_i)) else $error("channel field wrong");
   AST_SPARE: assert property (st_q.result[stm_pkg::STM_RES_SPARE_HI] == 1'b0
      && st_q.result[stm_pkg::STM_RES_SPARE_LO] == 1'b0) else $error("spare bit set");
   AST_FRAME_HEAD: assert property ((push && st_q.tx_idx == 4'h0) |-> push_byte == 8'h40)
      else $error("frame does not open with sync");
   AST_RESTART: assert property ($rose(st_q.fsm == stm_pkg::ST_RESTART) |=> acq_restart_o ##1 !acq_restart_o)
      else $error("restart pulse wrong");
   AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   // Guard covers the whole run and is down when idle, so a restart never meets a half-kept store
   AST_PROTECT_RUN: assert property (st_q.fsm == stm_pkg::ST_RUN |-> store_protect_o)
      else $error("store protect dropped during run");
   AST_PROTECT_IDLE: assert property (st_q.fsm == stm_pkg::ST_IDLE |-> !store_protect_o)
      else $error("store protect left on while idle");
   AST_START_PULSE: assert property (test_start_o |=> !test_start_o)
      else $error("start pulse held");
   AST_TMO_RESULT: assert property ((st_q.fsm == stm_pkg::ST_RUN && !test_done_i
      && st_q.tmo_cnt >= TIMEOUT_CYC - 32'h1) |=> st_q.result[21:0] == 22'h377fff)
      else $error("timeout result wrong");
   // A stalled byte must not move or vanish while the sink holds off
   AST_TX_HOLD: assert property ((tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o))
      else $error("response byte lost under back-pressure");
   AST_ACK_TIMING: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack not one cycle after request");

   COV_REQ: cover property (req_hit && st_q.fsm == stm_pkg::ST_IDLE);
   COV_TMO: cover property (st_q.fsm == stm_pkg::ST_RUN ##1 st_q.tmo_flag);
   COV_FULL: cover property ((st_q.fsm == stm_pkg::ST_SEND && !fifo_rdy) ##1 fifo_rdy);
   COV_RESTART: cover property (acq_restart_o);
endmodule // stm_self_test
`default_nettype wire

// [hdl/stm_pkg.sv]
`default_nettype none
package stm_pkg;
   // Clock and self-test time budget
   localparam longint unsigned STM_CLK_HZ = 64'd100_000_000;
   localparam longint unsigned STM_TEST_MAX_S = 64'd10;
   localparam int unsigned STM_TEST_MAX_CYC = 32'(STM_TEST_MAX_S * STM_CLK_HZ);

   // Frame bytes
   localparam logic [7:0] STM_SYNC_BYTE = 8'h40;
   localparam logic [7:0] STM_ID_HI = 8'h49;
   localparam logic [7:0] STM_ID_LO = 8'h61;
   localparam logic [7:0] STM_REQ_CSUM = 8'h28;
   localparam logic [7:0] STM_CR = 8'h0d;
   localparam logic [7:0] STM_LF = 8'h0a;
   localparam logic [2:0] STM_REQ_LEN = 3'h7;
   localparam logic [3:0] STM_RSP_LEN = 4'ha;

   // Register offsets (byte addresses)
   localparam logic [7:0] STM_ADR_CTRL = 8'h00;
   localparam logic [7:0] STM_ADR_STATUS = 8'h04;
   localparam logic [7:0] STM_ADR_RESULT = 8'h08;

   // Field positions
   localparam int STM_CTRL_EN_BIT = 0;
   localparam int STM_CTRL_GO_BIT = 1;
   localparam int STM_STAT_BUSY_BIT = 0;
   localparam int STM_STAT_DONE_BIT = 1;
   localparam int STM_STAT_TMO_BIT = 2;
   localparam int STM_RES_ANT_LSB = 22;
   localparam int STM_RES_SPARE_HI = 19;
   localparam int STM_RES_SPARE_LO = 15;

   // Reset values
   localparam logic STM_CTRL_EN_RST = 1'b1;
   localparam logic [23:0] STM_RESULT_RST = 24'h000000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_SEND,
      ST_RESTART
   } stm_fsm_t;

   // Wishbone slave request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } stm_wb_req_t;

   // Check outcomes: misc order clk,temp,ram,rom,1khz,tsum,osum,msum
   typedef struct packed {
      logic [7:0] misc;
      logic [11:0] chan;
   } stm_chk_t;

   typedef struct packed {
      stm_fsm_t fsm;
      logic [2:0] rx_idx;
      logic [3:0] tx_idx;
      logic ctrl_en;
      logic done_flag;
      logic tmo_flag;
      logic [23:0] result;
      logic [7:0] csum;
      logic [31:0] tmo_cnt;
      logic test_start;
      logic acq_restart;
      logic protect;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic [1:0] ant_s1;
      logic [1:0] ant_s2;
   } stm_state_t;
endpackage : stm_pkg
`default_nettype wire

// [test/stm_host_model.sv]
`default_nettype none

// Far side: check engine and serial sink, one clock with the unit
module stm_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic hang_i,
   input wire logic test_start_i,
   output logic test_done_o,
   output logic tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cnt_q;
   logic busy_q;
   logic [2:0] pace_q;

   // Checks end a fixed time after start; hang mode never ends them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 6'h00;
         busy_q <= 1'b0;
         pace_q <= 3'h0;
         test_done_o <= 1'b0;
      end else begin
         pace_q <= pace_q + 3'h1;
         test_done_o <= 1'b0;
         if (test_start_i) begin
            busy_q <= 1'b1;
            cnt_q <= slow_i ? 6'h28 : 6'h03;
         end else if (busy_q && !hang_i) begin
            if (cnt_q == 6'h00) begin
               busy_q <= 1'b0;
               test_done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 6'h01;
            end
         end
      end
   end

   // Slow sink takes one byte in eight, so the queue backs up
   assign tx_ready_o = !slow_i || pace_q == 3'h0;
endmodule // stm_host_model

`default_nettype wire

// [test/tb.sv]
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] ant;
      logic [7:0] misc;
      logic [11:0] chan;
      logic slow;
      logic [23:0] res;
   } stm_row_t;
   localparam logic [55:0] REQ = 56'h40404961280d0a;
   // Inputs beside the result field they must give
   stm_row_t rows [5] = '{
      '{2'h0, 8'h00, 12'h000, 1'b0, 24'h000000},
      '{2'h1, 8'h80, 12'h800, 1'b1, 24'h600800},
      '{2'h2, 8'h40, 12'h001, 1'b0, 24'h900001},
      '{2'h3, 8'h3f, 12'h000, 1'b0, 24'hc77000},
      '{2'h0, 8'hff, 12'hfff, 1'b1, 24'h377fff}};
   logic clk, rst, cyc, stb, we, rxv, txv, txr, start, done, prot, acq, ack, slow, hang;
   logic [1:0] ant;
   logic [7:0] adr, rxd, txd, misc;
   logic [11:0] chan;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   logic [79:0] f;
   int num_errors = 0;
   int cmp_count = 0;
   int n_start = 0;
   int n_acq = 0;
   int n_prot = 0;

   stm_self_test #(.TIMEOUT_CYC(50), .FIFO_DEPTH(4)) DUT (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .rx_valid_i(rxv), .rx_data_i(rxd), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr),
      .ant_sense_i(ant), .test_start_o(start), .test_done_i(done), .test_misc_fail_i(misc),
      .test_chan_fail_i(chan), .store_protect_o(prot), .acq_restart_o(acq));

   stm_host_model host (
      .clk_i(clk), .rst_i(rst), .slow_i(slow), .hang_i(hang),
      .test_start_i(start), .test_done_o(done), .tx_ready_o(txr));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulse counters; stores must stay guarded when the checks end
   always @(posedge clk) begin
      if (start === 1'b1) n_start++;
      if (acq === 1'b1) n_acq++;
      if (done === 1'b1 && prot !== 1'b1) n_prot++;
   end

   task close_out;
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check(input string nm, input logic [79:0] s, input logic [79:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One classic cycle; waits for ack however long it takes, up to a bound
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         num_errors++;
         close_out();
      end
   endtask

   task send_req;
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         rxv <= 1'b1;
         rxd <= REQ[55-8*i -: 8];
      end
      @(posedge clk);
      rxv <= 1'b0;
   endtask

   task get_frame;
      int k;
      k = 0;
      // Bounded wait that takes the next ten bytes out as the response
      for (int n = 0; n < 3000 && k < 10; n++) begin
         @(posedge clk);
         if (txv === 1'b1 && txr === 1'b1) begin
            f = {f[71:0], txd};
            k++;
         end
      end
      if (k < 10) begin
         num_errors++;
         close_out();
      end
   endtask

   task exp_frame(input logic [23:0] r);
      logic [7:0] c;
      c = 8'h49 ^ 8'h61 ^ r[23:16] ^ r[15:8] ^ r[7:0];
      check("frame", f, {32'h40404961, r, c, 16'h0d0a});
   endtask

   task run(input stm_row_t r);
      ant <= r.ant;
      misc <= r.misc;
      chan <= r.chan;
      slow <= r.slow;
      repeat (4) @(posedge clk);
      send_req();
      get_frame();
      exp_frame(r.res);
      wb(1'b0, stm_pkg::STM_ADR_RESULT, 32'h0);
      check("result", q, r.res);
      wb(1'b0, stm_pkg::STM_ADR_STATUS, 32'h0);
      check("status", q, 32'h2);
      wb(1'b1, stm_pkg::STM_ADR_STATUS, 32'h2);
      wb(1'b0, stm_pkg::STM_ADR_STATUS, 32'h0);
      check("status_clr", q, 32'h0);
      check("restarts", n_acq, n_start);
   endtask

   initial begin
      rst = 1'b1;
      {cyc, stb, we, rxv, slow, hang} = 6'h00;
      adr = 8'h00;
      sel = 4'hf;
      wdat = 32'h0;
      rxd = 8'h00;
      ant = 2'h0;
      misc = 8'h00;
      chan = 12'h000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Reset values and an unmapped place
      wb(1'b0, stm_pkg::STM_ADR_CTRL, 32'h0);
      check("ctrl_rst", q, 32'h1);
      wb(1'b0, stm_pkg::STM_ADR_STATUS, 32'h0);
      check("status_rst", q, 32'h0);
      wb(1'b0, stm_pkg::STM_ADR_RESULT, 32'h0);
      check("result_rst", q, 32'h0);
      wb(1'b1, 8'h0c, 32'h0);
      wb(1'b0, 8'h0c, 32'h0);
      check("unmapped", q, 32'h0);
      wb(1'b0, stm_pkg::STM_ADR_CTRL, 32'h0);
      check("ctrl_kept", q, 32'h1);
      foreach (rows[i]) run(rows[i]);
      check("starts", n_start, 5);
      // Serial requests are ignored while disabled; the register start still works
      wb(1'b1, stm_pkg::STM_ADR_CTRL, 32'h0);
      send_req();
      repeat (10) @(posedge clk);
      check("starts_off", n_start, 5);
      wb(1'b1, stm_pkg::STM_ADR_CTRL, 32'h3);
      get_frame();
      exp_frame(24'h377fff);
      wb(1'b0, stm_pkg::STM_ADR_CTRL, 32'h0);
      check("go_clears", q, 32'h1);
      // Hung checks time out with every item failed; a second request is dropped
      hang <= 1'b1;
      ant <= 2'h3;
      misc <= 8'h00;
      chan <= 12'h000;
      repeat (4) @(posedge clk);
      send_req();
      send_req();
      get_frame();
      exp_frame(24'hf77fff);
      wb(1'b0, stm_pkg::STM_ADR_STATUS, 32'h0);
      check("tmo", q[2], 1'b1);
      wb(1'b1, stm_pkg::STM_ADR_STATUS, 32'h4);
      wb(1'b0, stm_pkg::STM_ADR_STATUS, 32'h0);
      check("tmo_clr", q[2], 1'b0);
      check("starts_busy", n_start, 7);
      check("restarts_all", n_acq, 7);
      check("guard", n_prot, 0);
      // Reset in mid-test drops the run and restores the register defaults
      wb(1'b1, stm_pkg::STM_ADR_CTRL, 32'h3);
      repeat (4) @(posedge clk);
      check("prot_run", prot, 1'b1);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      check("prot_rst", prot, 1'b0);
      check("txv_rst", txv, 1'b0);
      wb(1'b0, stm_pkg::STM_ADR_STATUS, 32'h0);
      check("status_rst2", q, 32'h0);
      wb(1'b0, stm_pkg::STM_ADR_RESULT, 32'h0);
      check("result_rst2", q, 32'h0);
      wb(1'b0, stm_pkg::STM_ADR_CTRL, 32'h0);
      check("ctrl_rst2", q, 32'h1);
      close_out();
   end
endmodule // tb

`default_nettype wire
